// >>> rtl/icr_pkg.sv
// Purpose: Shared constants for the serial bus controller register bank.
// Assumes: 32-bit AHB-Lite word access, one clock.
// Notes:   Offsets are byte addresses.
package icr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_OWN_ADDRESS   = 8'h00;
    localparam logic [7:0] OFS_INT_MASK      = 8'h04;
    localparam logic [7:0] OFS_INT_STATUS    = 8'h08;
    localparam logic [7:0] OFS_CLK_LOW       = 8'h0C;
    localparam logic [7:0] OFS_CLK_HIGH      = 8'h10;
    localparam logic [7:0] OFS_DATA_COUNT    = 8'h14;
    localparam logic [7:0] OFS_RX_DATA       = 8'h18;
    localparam logic [7:0] OFS_TARGET_ADDR   = 8'h1C;
    localparam logic [7:0] OFS_TX_DATA       = 8'h20;
    localparam logic [7:0] OFS_MODE_CONTROL  = 8'h24;
    localparam logic [7:0] OFS_INT_VECTOR    = 8'h28;
    localparam logic [7:0] OFS_EXT_MODE      = 8'h2C;
    localparam logic [7:0] OFS_PRESCALER     = 8'h30;
    localparam logic [7:0] OFS_ID_ONE        = 8'h34;
    localparam logic [7:0] OFS_ID_TWO        = 8'h38;
    localparam logic [7:0] OFS_INT_CLEAR     = 8'h40;
    localparam logic [7:0] OFS_POWER_STATUS  = 8'h44;
    // ==========================================================
    // Field layouts and widths
    localparam int          OWN_ADDR_W       = 10;
    localparam int          SHORT_ADDR_W     = 7;
    localparam int          NUM_EVENTS       = 7;
    localparam int          EV_ADDR_TARGET   = 6;
    localparam int          MODE_TEN_BIT     = 8;
    localparam int          MODE_FREE_RUN    = 14;
    localparam int          MODE_MASTER      = 10;
    localparam logic [31:0] RESET_ZERO       = 32'h0000_0000;
    localparam logic [31:0] ID_ONE_VALUE     = 32'h0000_0101; // Arbitrary value.
    localparam logic [31:0] ID_TWO_VALUE     = 32'h0000_0002; // Arbitrary value.
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'b10;
    localparam logic [1:0]  HTRANS_SEQ       = 2'b11;
    // ==========================================================
    // Suspend handling states
    typedef enum logic [2:0] {
        ST_RUN     = 3'b001,
        ST_DRAIN   = 3'b010,
        ST_HALTED  = 3'b100
    } icr_susp_t;
endpackage

// >>> rtl/icr_sync.sv
// Purpose: Three-stage synchroniser, change accepted when stages two and three agree.
// Assumes: Input is asynchronous to clock_i.
// Notes:   Stage one feeds only stage two.
`timescale 1ns/10ps
module icr_sync (
    input  wire logic clock_i,   // Clock.
    input  wire logic rst_n_i,   // Async reset, low.
    input  wire logic enable_i,  // Clock enable.
    input  wire logic async_i,   // Raw input.
    output logic      level_o    // Filtered level.
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_o <= 1'b0;
        end else if (enable_i) begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_o <= s3_q;
            end
        end
    end
endmodule

// >>> rtl/icr_addr_match.sv
// Purpose: Compares a received bus address against the own address.
// Assumes: Same clock as the register bank.
// Notes:   Registered output, one cycle after the strobe.
`timescale 1ns/10ps
module icr_addr_match
    import icr_pkg::*;
(
    input  wire logic                  clock_i,    // Clock.
    input  wire logic                  rst_n_i,    // Async reset, low.
    input  wire logic                  enable_i,   // Clock enable.
    input  wire logic [OWN_ADDR_W-1:0] own_i,      // Own address field.
    input  wire logic                  ten_bit_i,  // Ten-bit mode.
    input  wire logic [OWN_ADDR_W-1:0] rx_addr_i,  // Received address.
    input  wire logic                  strobe_i,   // Address valid pulse.
    output logic                       hit_o       // Match pulse.
);
    function automatic logic addr_hit(input logic [OWN_ADDR_W-1:0] own, input logic [OWN_ADDR_W-1:0] rx,
                                      input logic ten);
        logic m;
        m = ten ? (own == rx) : (own[SHORT_ADDR_W-1:0] == rx[SHORT_ADDR_W-1:0]);
        return m || (rx == '0);
    endfunction

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hit_o <= 1'b0;
        end else if (enable_i) begin
            hit_o <= strobe_i && addr_hit(own_i, rx_addr_i, ten_bit_i);
        end
    end
endmodule

// >>> rtl/icr_regbank.sv
// Purpose: AHB-Lite register bank of a two-wire serial bus controller.
// Assumes: Single word transfers; the protocol engine sits outside and drives the event ports.
// Notes:   Zero wait states; every response is OKAY.
//
// Behaviour
// - On suspend, bus data exchange stops when free-run is 0 and continues when it is 1.
// - A suspended master finishes its current byte before halting, a target halts at once.
// - Fifteen registers are decoded at word offsets 0h to 38h in the documented order.
// - The own-address register holds a ten-bit read/write field that resets to zero.
// - In seven-bit mode only bits 6 to 0 of the own address are compared.
// - In ten-bit mode all ten own-address bits are compared.
// - Reserved upper bits of own address and mask read zero and ignore writes.
// - The mask register holds seven read/write enables that reset to zero.
// - Each mask bit enables its event's request when 1 and disables it when 0.
// - An outside power controller moves the block into and out of reduced power.
// - A set event flag forwards an interrupt only while its mask bit is 1.
// - The addressed-as-target event fires on an own-address match or an all-zero address.
`timescale 1ns/10ps
module icr_regbank
    import icr_pkg::*;
(
    input  wire logic                  clock_i,        // Clock, 200 MHz.
    input  wire logic                  rst_n_i,        // Async reset, low.
    input  wire logic                  clk_en_i,       // Freezes all state when low.
    input  wire logic                  hsel_i,         // AHB select.
    input  wire logic [7:0]            haddr_i,        // AHB address.
    input  wire logic [1:0]            htrans_i,       // AHB transfer type.
    input  wire logic                  hwrite_i,       // AHB write.
    input  wire logic [2:0]            hsize_i,        // AHB size.
    input  wire logic [31:0]           hwdata_i,       // AHB write data.
    input  wire logic                  hready_i,       // AHB ready in.
    output logic [31:0]                hrdata_o,       // AHB read data.
    output logic                       hreadyout_o,    // AHB ready out.
    output logic                       hresp_o,        // AHB response.
    input  wire logic [NUM_EVENTS-1:0] event_i,        // Event pulses from engine.
    input  wire logic [OWN_ADDR_W-1:0] rx_addr_i,      // Received bus address.
    input  wire logic                  rx_addr_vld_i,  // Received address strobe.
    input  wire logic                  byte_done_i,    // Engine finished a byte.
    input  wire logic                  suspend_i,      // Emulation suspend, async.
    input  wire logic                  sleep_req_i,    // Power controller request, async.
    output logic                       sleep_ack_o,    // Reduced power entered.
    output logic                       xfer_enable_o,  // Engine may exchange data.
    output logic [OWN_ADDR_W-1:0]      own_addr_o,     // Effective own address.
    output logic [31:0]                mode_o,         // Mode control contents.
    output logic                       irq_o           // Level interrupt.
);
    // ==========================================================
    // Storage
    logic [OWN_ADDR_W-1:0] own_addr_field_q;
    logic [NUM_EVENTS-1:0] interrupt_mask_q;
    logic [NUM_EVENTS-1:0] status_q;
    logic [31:0]           clk_low_q;
    logic [31:0]           clk_high_q;
    logic [31:0]           data_count_q;
    logic [31:0]           target_addr_q;
    logic [31:0]           tx_data_q;
    logic [31:0]           mode_control_q;
    logic [31:0]           ext_mode_q;
    logic [31:0]           prescaler_q;
    logic                  wr_pend_q;
    logic [7:0]            addr_q;
    logic                  aas_hit;
    logic                  suspend_s;
    logic                  sleep_s;
    logic [NUM_EVENTS-1:0] ev_all;
    logic [NUM_EVENTS-1:0] clr_bits;
    logic [31:0]           rdata_d;
    logic                  ten_bit_addr_mode;
    icr_susp_t             susp_q;

    assign ten_bit_addr_mode = mode_control_q[MODE_TEN_BIT];

    function automatic logic ahb_go(input logic sel, input logic [1:0] tr, input logic rdy);
        return sel && rdy && (tr == HTRANS_NONSEQ || tr == HTRANS_SEQ);
    endfunction

    // ==========================================================
    // Helpers
    icr_sync u_sync_susp (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .enable_i (clk_en_i),
        .async_i  (suspend_i),
        .level_o  (suspend_s)
    );

    icr_sync u_sync_sleep (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .enable_i (clk_en_i),
        .async_i  (sleep_req_i),
        .level_o  (sleep_s)
    );

    icr_addr_match u_match (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .enable_i  (clk_en_i),
        .own_i     (own_addr_field_q),
        .ten_bit_i (ten_bit_addr_mode),
        .rx_addr_i (rx_addr_i),
        .strobe_i  (rx_addr_vld_i),
        .hit_o     (aas_hit)
    );

    // ==========================================================
    // AHB address phase capture
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_q <= 1'b0;
            addr_q    <= '0;
        end else if (clk_en_i) begin
            if (hready_i) begin
                wr_pend_q <= ahb_go(hsel_i, htrans_i, hready_i) && hwrite_i;
                addr_q    <= {haddr_i[7:2], 2'b00};
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else if (clk_en_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // ==========================================================
    // Writable registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            own_addr_field_q <= '0;
            interrupt_mask_q <= '0;
            clk_low_q        <= RESET_ZERO;
            clk_high_q       <= RESET_ZERO;
            data_count_q     <= RESET_ZERO;
            target_addr_q    <= RESET_ZERO;
            tx_data_q        <= RESET_ZERO;
            mode_control_q   <= RESET_ZERO;
            ext_mode_q       <= RESET_ZERO;
            prescaler_q      <= RESET_ZERO;
        end else if (clk_en_i && wr_pend_q) begin
            unique case (addr_q)
                OFS_OWN_ADDRESS:  own_addr_field_q <= hwdata_i[OWN_ADDR_W-1:0];
                OFS_INT_MASK:     interrupt_mask_q <= hwdata_i[NUM_EVENTS-1:0];
                OFS_CLK_LOW:      clk_low_q        <= hwdata_i;
                OFS_CLK_HIGH:     clk_high_q       <= hwdata_i;
                OFS_DATA_COUNT:   data_count_q     <= hwdata_i;
                OFS_TARGET_ADDR:  target_addr_q    <= hwdata_i;
                OFS_TX_DATA:      tx_data_q        <= hwdata_i;
                OFS_MODE_CONTROL: mode_control_q   <= hwdata_i;
                OFS_EXT_MODE:     ext_mode_q       <= hwdata_i;
                OFS_PRESCALER:    prescaler_q      <= hwdata_i;
                default:          ;
            endcase
        end
    end

    // ==========================================================
    // Event status: set wins over clear
    assign ev_all   = {aas_hit | event_i[EV_ADDR_TARGET], event_i[EV_ADDR_TARGET-1:0]};
    assign clr_bits = (wr_pend_q && addr_q == OFS_INT_CLEAR) ? hwdata_i[NUM_EVENTS-1:0] : '0;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q <= '0;
        end else if (clk_en_i) begin
            status_q <= (status_q & ~clr_bits) | ev_all;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_o <= |(((status_q & ~clr_bits) | ev_all) & interrupt_mask_q);
        end
    end

    // ==========================================================
    // Read mux
    always_comb begin
        rdata_d = RESET_ZERO;
        unique case ({haddr_i[7:2], 2'b00})
            OFS_OWN_ADDRESS:  rdata_d = {{(32-OWN_ADDR_W){1'b0}}, own_addr_field_q};
            OFS_INT_MASK:     rdata_d = {{(32-NUM_EVENTS){1'b0}}, interrupt_mask_q};
            OFS_INT_STATUS:   rdata_d = {{(32-NUM_EVENTS){1'b0}}, status_q};
            OFS_CLK_LOW:      rdata_d = clk_low_q;
            OFS_CLK_HIGH:     rdata_d = clk_high_q;
            OFS_DATA_COUNT:   rdata_d = data_count_q;
            OFS_RX_DATA:      rdata_d = RESET_ZERO;
            OFS_TARGET_ADDR:  rdata_d = target_addr_q;
            OFS_TX_DATA:      rdata_d = tx_data_q;
            OFS_MODE_CONTROL: rdata_d = mode_control_q;
            OFS_INT_VECTOR:   rdata_d = RESET_ZERO;
            OFS_EXT_MODE:     rdata_d = ext_mode_q;
            OFS_PRESCALER:    rdata_d = prescaler_q;
            OFS_ID_ONE:       rdata_d = ID_ONE_VALUE;
            OFS_ID_TWO:       rdata_d = ID_TWO_VALUE;
            OFS_POWER_STATUS: rdata_d = {31'h0000_0000, sleep_ack_o};
            default:          rdata_d = RESET_ZERO;
        endcase
    end

    // Read data is registered in the address phase so it stands in the data phase.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= RESET_ZERO;
        end else if (clk_en_i) begin
            hrdata_o <= (ahb_go(hsel_i, htrans_i, hready_i) && !hwrite_i) ? rdata_d : RESET_ZERO;
        end
    end

    // ==========================================================
    // Suspend and power handling
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            susp_q <= ST_RUN;
        end else if (clk_en_i) begin
            unique case (susp_q)
                ST_RUN: begin
                    if (suspend_s && !mode_control_q[MODE_FREE_RUN]) begin
                        susp_q <= mode_control_q[MODE_MASTER] ? ST_DRAIN : ST_HALTED;
                    end
                end
                ST_DRAIN: begin
                    if (!suspend_s || mode_control_q[MODE_FREE_RUN]) begin
                        susp_q <= ST_RUN;
                    end else if (byte_done_i) begin
                        susp_q <= ST_HALTED;
                    end
                end
                ST_HALTED: begin
                    if (!suspend_s || mode_control_q[MODE_FREE_RUN]) begin
                        susp_q <= ST_RUN;
                    end
                end
                default: susp_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sleep_ack_o <= 1'b0;
        end else if (clk_en_i) begin
            sleep_ack_o <= sleep_s;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xfer_enable_o <= 1'b0;
            own_addr_o    <= '0;
            mode_o        <= RESET_ZERO;
        end else if (clk_en_i) begin
            xfer_enable_o <= (susp_q != ST_HALTED) && !sleep_s;
            own_addr_o    <= ten_bit_addr_mode ? own_addr_field_q
                           : {{(OWN_ADDR_W-SHORT_ADDR_W){1'b0}}, own_addr_field_q[SHORT_ADDR_W-1:0]};
            mode_o        <= mode_control_q;
        end
    end
endmodule

// >>> test/icr_regbank_assertions.sv
// Purpose: Port-level checks of the serial bus register bank.
// Assumes: One clock domain; hready_i is fed from hreadyout_o.
// Notes:   Long holds cover the three-flop synchroniser lag.
`timescale 1ns/10ps
module icr_regbank_assertions
    import icr_pkg::*;
(
    input wire logic                  clock_i,       // Clock.
    input wire logic                  rst_n_i,       // Reset, low.
    input wire logic                  clk_en_i,      // Run enable.
    input wire logic                  hsel_i,        // Select.
    input wire logic [7:0]            haddr_i,       // Address.
    input wire logic [1:0]            htrans_i,      // Transfer type.
    input wire logic                  hwrite_i,      // Write.
    input wire logic                  hready_i,      // Ready in.
    input wire logic [31:0]           hrdata_o,      // Read data.
    input wire logic                  hreadyout_o,   // Ready out.
    input wire logic                  hresp_o,       // Response.
    input wire logic [NUM_EVENTS-1:0] event_i,       // Events.
    input wire logic                  rx_addr_vld_i, // Address strobe.
    input wire logic                  suspend_i,     // Suspend.
    input wire logic                  sleep_req_i,   // Sleep request.
    input wire logic                  sleep_ack_o,   // Sleep ack.
    input wire logic                  xfer_enable_o, // Transfer enable.
    input wire logic [OWN_ADDR_W-1:0] own_addr_o,    // Own address.
    input wire logic [31:0]           mode_o,        // Mode copy.
    input wire logic                  irq_o          // Interrupt.
);
    // ==========================================================
    // Checks
    logic rd_take;
    assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i && clk_en_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_resp_okay: assert property (hresp_o == 1'b0 && hreadyout_o)
        else $error("slave response not OKAY and ready");
    chk_rdata_idle: assert property (hrdata_o != 32'h0000_0000 |-> $past(rd_take))
        else $error("read data outside a read data phase");
    chk_id_two: assert property ($past(rd_take && haddr_i == OFS_ID_TWO) |-> hrdata_o == ID_TWO_VALUE)
        else $error("second id register read wrong");
    chk_unmapped_zero: assert property ($past(rd_take && haddr_i == 8'h3C) |-> hrdata_o == RESET_ZERO)
        else $error("unmapped read not zero");
    chk_irq_cause: assert property ($rose(irq_o) |-> $past(event_i) != '0 || $past(rx_addr_vld_i, 2) ||
        $past(hsel_i && hwrite_i, 2) || $past(hsel_i && hwrite_i, 3))
        else $error("interrupt rose without event or write");
    chk_short_addr: assert property (!mode_o[MODE_TEN_BIT] && $past(!mode_o[MODE_TEN_BIT])
        |-> own_addr_o[9:7] == 3'b000)
        else $error("upper own address bits used in short mode");
    chk_free_runs: assert property ((mode_o[MODE_FREE_RUN] && !sleep_ack_o && clk_en_i) [*3] |-> xfer_enable_o)
        else $error("free-run mode stopped transfers");
    chk_target_halt: assert property ((suspend_i && clk_en_i && !mode_o[MODE_MASTER] &&
        !mode_o[MODE_FREE_RUN]) [*7] |-> !xfer_enable_o)
        else $error("suspended target kept transferring");
    chk_sleep_follow: assert property ((sleep_req_i == $past(sleep_req_i)) [*6] |-> sleep_ack_o == sleep_req_i)
        else $error("sleep ack does not follow request");
    cov_irq: cover property ($rose(irq_o));
    cov_halt: cover property ($fell(xfer_enable_o));
    cov_sleep: cover property ($rose(sleep_ack_o));
endmodule

bind icr_regbank icr_regbank_assertions i_chk (.clock_i, .rst_n_i, .clk_en_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .event_i, .rx_addr_vld_i, .suspend_i,
    .sleep_req_i, .sleep_ack_o, .xfer_enable_o, .own_addr_o, .mode_o, .irq_o);

// >>> test/icr_engine_model.sv
// Purpose: Protocol engine stand-in feeding events and received addresses.
// Assumes: Tasks are called by the bench just off a clock edge.
// Notes:   A byte completes every eight enabled cycles.
`timescale 1ns/10ps
module icr_engine_model
    import icr_pkg::*;
(
    input  wire logic                  clock_i,       // Clock.
    input  wire logic                  rst_n_i,       // Reset, low.
    input  wire logic                  xfer_enable_i, // Data may move.
    output logic [NUM_EVENTS-1:0]      event_o,       // Event pulses.
    output logic [OWN_ADDR_W-1:0]      rx_addr_o,     // Received address.
    output logic                       rx_addr_vld_o, // Address strobe.
    output logic                       byte_done_o    // Byte finished.
);
    logic [2:0] bit_cnt_q;
    initial begin
        event_o = '0;
        rx_addr_o = '0;
        rx_addr_vld_o = 1'b0;
    end
    // Byte pacing stalls while the block withholds the enable.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_q <= 3'd0;
        end else if (xfer_enable_i) begin
            bit_cnt_q <= bit_cnt_q + 3'd1;
        end
    end
    assign byte_done_o = xfer_enable_i && (bit_cnt_q == 3'd7);
    task automatic pulse(input logic [NUM_EVENTS-1:0] ev);
        event_o <= ev;
        @(posedge clock_i);
        event_o <= '0;
    endtask
    // A released address bus shows the inverse, never the last value.
    task automatic addr(input logic [OWN_ADDR_W-1:0] a);
        rx_addr_o <= a;
        rx_addr_vld_o <= 1'b1;
        @(posedge clock_i);
        rx_addr_vld_o <= 1'b0;
        rx_addr_o <= ~a;
    endtask
endmodule

// >>> test/tb.sv
// Purpose: Self-checking bench of the serial bus register bank.
// Assumes: Zero-wait slave; read data stands in the data phase.
// Notes:   Run enable and transfer size are tied.
`timescale 1ns/10ps
module tb
    import icr_pkg::*;
;
    logic                  clock_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic                  suspend_i, sleep_req_i, sleep_ack_o, xfer_enable_o, irq_o;
    logic                  rx_addr_vld_i, byte_done_i;
    logic [1:0]            htrans_i;
    logic [7:0]            haddr_i;
    logic [31:0]           hwdata_i, hrdata_o, mode_o;
    logic [NUM_EVENTS-1:0] event_i;
    logic [OWN_ADDR_W-1:0] rx_addr_i, own_addr_o;
    int                    err_count = 0;
    int                    cmp_count = 0;
    icr_regbank i_icr_regbank (.clock_i, .rst_n_i, .clk_en_i(1'b1), .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
        .hresp_o, .event_i, .rx_addr_i, .rx_addr_vld_i, .byte_done_i, .suspend_i, .sleep_req_i,
        .sleep_ack_o, .xfer_enable_o, .own_addr_o, .mode_o, .irq_o);
    icr_engine_model i_icr_engine_model (.clock_i, .rst_n_i, .xfer_enable_i(xfer_enable_o),
        .event_o(event_i), .rx_addr_o(rx_addr_i), .rx_addr_vld_o(rx_addr_vld_i), .byte_done_o(byte_done_i));
    always #2.5 clock_i = ~clock_i;
    // ==========================================================
    // Shared tasks
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int n);
        if (n >= 50) begin
            err_count++;
            report_and_stop;
        end
    endtask
    task tick;
        @(posedge clock_i);
        #1;
    endtask
    task automatic wait_rdy;
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge clock_i);
            if (hreadyout_o === 1'b1) break;
        end
        bound(n);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= HTRANS_NONSEQ;
        hwrite_i <= w;
        wait_rdy;
        hsel_i <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        wait_rdy;
        rd = hrdata_o;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask
    // ==========================================================
    // Scenarios
    task t_reset;
        rdc(OFS_OWN_ADDRESS, RESET_ZERO);
        rdc(OFS_INT_MASK, RESET_ZERO);
        rdc(OFS_ID_ONE, ID_ONE_VALUE);
        rdc(OFS_ID_TWO, ID_TWO_VALUE);
        rdc(OFS_RX_DATA, RESET_ZERO);
        rdc(8'h3C, RESET_ZERO);
        $display("reset values done");
    endtask
    task t_reserved;
        wr(OFS_OWN_ADDRESS, 32'hFFFF_FFFF);
        rdc(OFS_OWN_ADDRESS, 32'h0000_03FF);
        wr(OFS_INT_MASK, 32'hFFFF_FFFF);
        rdc(OFS_INT_MASK, 32'h0000_007F);
        rdc(8'h3C, RESET_ZERO);
        rdc(OFS_OWN_ADDRESS, 32'h0000_03FF);
        chk(own_addr_o, 32'h0000_007F);
        $display("reserved bits done");
    endtask
    task t_irq;
        wr(OFS_INT_MASK, 32'h0000_0000);
        i_icr_engine_model.pulse(7'h7F);
        #1;
        chk(irq_o, 1'b0);
        rdc(OFS_INT_STATUS, 32'h0000_007F);
        wr(OFS_INT_CLEAR, 32'h0000_007F);
        rdc(OFS_INT_STATUS, 32'h0000_0000);
        for (int k = 0; k < NUM_EVENTS; k++) begin
            wr(OFS_INT_MASK, 32'h1 << k);
            i_icr_engine_model.pulse(~(7'h1 << k));
            #1;
            chk(irq_o, 1'b0);
            i_icr_engine_model.pulse(7'h1 << k);
            #1;
            chk(irq_o, 1'b1);
            wr(OFS_INT_CLEAR, 32'h0000_007F);
            tick;
            chk(irq_o, 1'b0);
        end
        $display("interrupts done");
    endtask
    task t_match;
        logic [9:0]  rx [6] = '{10'h025, 10'h1A5, 10'h000, 10'h026, 10'h025, 10'h2A5};
        logic [5:0]  ten = 6'b110000;
        logic [5:0]  hit = 6'b100111;
        logic [31:0] r;
        wr(OFS_INT_MASK, 32'h0000_0000);
        wr(OFS_OWN_ADDRESS, 32'h0000_02A5);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_MODE_CONTROL, 32'(ten[i]) << MODE_TEN_BIT);
            wr(OFS_INT_CLEAR, 32'h0000_007F);
            tick;
            chk(own_addr_o, ten[i] ? 32'h0000_02A5 : 32'h0000_0025);
            chk(mode_o[MODE_TEN_BIT], ten[i]);
            i_icr_engine_model.addr(rx[i]);
            tick;
            tick;
            bus(1'b0, OFS_INT_STATUS, 32'h0000_0000, r);
            chk(r[EV_ADDR_TARGET], hit[i]);
        end
        $display("address match done");
    endtask
    task t_suspend;
        int   n;
        logic saw;
        wr(OFS_MODE_CONTROL, 32'h1 << MODE_FREE_RUN);
        suspend_i <= 1'b1;
        repeat (10) tick;
        chk(xfer_enable_o, 1'b1);
        wr(OFS_MODE_CONTROL, 32'h0000_0000);
        for (n = 0; n < 50 && xfer_enable_o !== 1'b0; n++) tick;
        bound(n);
        suspend_i <= 1'b0;
        repeat (10) tick;
        chk(xfer_enable_o, 1'b1);
        wr(OFS_MODE_CONTROL, 32'h1 << MODE_MASTER);
        suspend_i <= 1'b1;
        saw = 1'b0;
        for (n = 0; n < 50 && xfer_enable_o !== 1'b0; n++) begin
            saw = saw | byte_done_i;
            tick;
        end
        bound(n);
        chk(saw, 1'b1);
        suspend_i <= 1'b0;
        $display("suspend done");
    endtask
    task t_sleep;
        int n;
        sleep_req_i <= 1'b1;
        for (n = 0; n < 50 && sleep_ack_o !== 1'b1; n++) tick;
        bound(n);
        rdc(OFS_POWER_STATUS, 32'h0000_0001);
        sleep_req_i <= 1'b0;
        for (n = 0; n < 50 && sleep_ack_o !== 1'b0; n++) tick;
        bound(n);
        $display("sleep done");
    endtask
    initial begin
        clock_i = 1'b0;
        rst_n_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 8'h00;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hwdata_i = 32'h0000_0000;
        suspend_i = 1'b0;
        sleep_req_i = 1'b0;
        repeat (6) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        tick;
        t_reset;
        t_reserved;
        t_irq;
        t_match;
        t_suspend;
        t_sleep;
        report_and_stop;
    end
endmodule
